// File: hw/rbt_half.sv
// rbt_half: one half of the transceiver, both registers
// assumes synchronised pins and one-cycle capture pulses
`timescale 1ns/1ps
`default_nettype none
module rbt_half #(
  parameter int WIDTH = rbt_pkg::RBT_HALF_WIDTH
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             output_enable_n,
  input  wire logic             transfer_direction,
  input  wire logic             source_select_a_to_b,
  input  wire logic             source_select_b_to_a,
  input  wire logic             capture_a_rise,
  input  wire logic             capture_b_rise,
  input  wire logic             force_isolate,
  input  wire logic [WIDTH-1:0] a_in,
  input  wire logic [WIDTH-1:0] b_in,
  output var  logic [WIDTH-1:0] a_out,
  output var  logic [WIDTH-1:0] a_oe,
  output var  logic [WIDTH-1:0] b_out,
  output var  logic [WIDTH-1:0] b_oe,
  output var  logic [WIDTH-1:0] stored_a,
  output var  logic [WIDTH-1:0] stored_b
);
  import rbt_pkg::*;
  logic             enabled;     // outputs allowed
  logic [WIDTH-1:0] next_a_out;  // next a drive value
  logic [WIDTH-1:0] next_a_oe;   // next a enables
  logic [WIDTH-1:0] next_b_out;  // next b drive value
  logic [WIDTH-1:0] next_b_oe;   // next b enables
  logic [WIDTH-1:0] next_st_a;   // next a register
  logic [WIDTH-1:0] next_st_b;   // next b register

  // --------------------------------------------------------
  // capture, drive select and direction
  // --------------------------------------------------------
  always_comb begin
    enabled    = !output_enable_n && !force_isolate;
    // capture ignores enable, direction and selects
    next_st_a  = capture_a_rise ? a_in : stored_a;
    next_st_b  = capture_b_rise ? b_in : stored_b;
    // only the chosen side drives, never both
    next_a_oe  = {WIDTH{enabled && !transfer_direction}};
    next_b_oe  = {WIDTH{enabled && transfer_direction}};
    // stored word is the pre-capture value on a clash
    next_a_out = source_select_b_to_a ? stored_b : b_in;
    next_b_out = source_select_a_to_b ? stored_a : a_in;
    if (!clk_en) begin
      next_st_a  = stored_a;
      next_st_b  = stored_b;
      next_a_oe  = a_oe;
      next_b_oe  = b_oe;
      next_a_out = a_out;
      next_b_out = b_out;
    end
  end

  // registers clear and ports float under reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stored_a <= '0;
      stored_b <= '0;
      a_oe     <= '0;
      b_oe     <= '0;
      a_out    <= '0;
      b_out    <= '0;
    end else begin
      stored_a <= next_st_a;
      stored_b <= next_st_b;
      a_oe     <= next_a_oe;
      b_oe     <= next_b_oe;
      a_out    <= next_a_out;
      b_out    <= next_b_out;
    end
  end
endmodule : rbt_half
`default_nettype wire

// File: hw/rbt_pkg.sv
// rbt_pkg: shared constants for the registered bus transceiver
// assumes a 32-bit classic wishbone slave with byte addressing
package rbt_pkg;
  // ----------------------------------------------------------
  // structure
  // ----------------------------------------------------------
  localparam int RBT_HALF_WIDTH  = 8;  // bits per half
  localparam int RBT_NUM_HALVES  = 2;  // independent halves
  localparam int RBT_CTL_PER_HALF = 6; // control pins per half
  // ----------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------
  localparam logic [7:0] RBT_OFS_ID      = 8'h00; // block tag
  localparam logic [7:0] RBT_OFS_CTRL    = 8'h04; // isolation
  localparam logic [7:0] RBT_OFS_STORE_A = 8'h08; // a registers
  localparam logic [7:0] RBT_OFS_STORE_B = 8'h0c; // b registers
  localparam logic [7:0] RBT_OFS_PINS    = 8'h10; // control pins
  localparam logic [7:0] RBT_OFS_COUNT   = 8'h14; // capture count
  // ----------------------------------------------------------
  // field positions
  // ----------------------------------------------------------
  localparam int RBT_CTRL_ISO_POS   = 0;  // force isolate, per half
  localparam int RBT_CTRL_CLR_POS   = 8;  // counter clear pulse
  localparam int RBT_PIN_OE_POS     = 0;  // output_enable_n
  localparam int RBT_PIN_DIR_POS    = 2;  // transfer_direction
  localparam int RBT_PIN_SAB_POS    = 4;  // source_select_a_to_b
  localparam int RBT_PIN_SBA_POS    = 6;  // source_select_b_to_a
  localparam int RBT_PIN_CPA_POS    = 8;  // capture_clock_a_side
  localparam int RBT_PIN_CPB_POS    = 10; // capture_clock_b_side
  localparam int RBT_CNT_B_POS      = 16; // b count in upper half
  // ----------------------------------------------------------
  // reset values
  // ----------------------------------------------------------
  localparam logic [1:0]  RBT_CTRL_ISO_RST = 2'h0;
  localparam logic [15:0] RBT_CNT_RST      = 16'h0000;
  localparam logic [31:0] RBT_DAT_RST      = 32'h0000_0000;
  // arbitrary neutral value, names no maker or part
  localparam logic [31:0] RBT_BLOCK_TAG    = 32'h0000_0001;
  // ----------------------------------------------------------
  // bus slave states
  // ----------------------------------------------------------
  typedef enum logic {RBT_WB_IDLE, RBT_WB_ACK} rbt_wb_state_e;
endpackage : rbt_pkg

// File: hw/rbt_sync.sv
// rbt_sync: two flip-flop synchroniser for a bundle of pins
// assumes each bit is independent; no word coherence given
`timescale 1ns/1ps
`default_nettype none
module rbt_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  import rbt_pkg::*;
  logic [WIDTH-1:0] meta;      // first stage, read only by second
  logic [WIDTH-1:0] next_meta; // next first stage
  logic [WIDTH-1:0] next_out;  // next second stage

  // --------------------------------------------------------
  // next values, frozen while the enable is low
  // --------------------------------------------------------
  always_comb begin
    next_meta = clk_en ? async_in : meta;
    next_out  = clk_en ? meta : sync_out;
  end

  // registers take only a constant under reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= next_meta;
      sync_out <= next_out;
    end
  end
endmodule : rbt_sync
`default_nettype wire

// File: hw/rbt_transceiver.sv
// rbt_transceiver: 16-bit registered bus transceiver top
// assumes all pins arrive asynchronously to core_clk and
// that the bench resolves each data wire from the enables
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rbt_transceiver #(
  parameter int HALF_WIDTH = rbt_pkg::RBT_HALF_WIDTH,
  parameter int NUM_HALVES = rbt_pkg::RBT_NUM_HALVES
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  input  wire logic [NUM_HALVES-1:0] output_enable_n,
  input  wire logic [NUM_HALVES-1:0] transfer_direction,
  input  wire logic [NUM_HALVES-1:0] capture_clock_a_side,
  input  wire logic [NUM_HALVES-1:0] capture_clock_b_side,
  input  wire logic [NUM_HALVES-1:0] source_select_a_to_b,
  input  wire logic [NUM_HALVES-1:0] source_select_b_to_a,
  input  wire logic [HALF_WIDTH*NUM_HALVES-1:0] port_a_data_in,
  output var  logic [HALF_WIDTH*NUM_HALVES-1:0] port_a_data_out,
  output var  logic [HALF_WIDTH*NUM_HALVES-1:0] port_a_data_oe,
  input  wire logic [HALF_WIDTH*NUM_HALVES-1:0] port_b_data_in,
  output var  logic [HALF_WIDTH*NUM_HALVES-1:0] port_b_data_out,
  output var  logic [HALF_WIDTH*NUM_HALVES-1:0] port_b_data_oe,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output var  logic [31:0]          wb_dat_o,
  output var  logic                 wb_ack_o
);
  import rbt_pkg::*;

  // ----------------------------------------------------------
  // sizes
  // ----------------------------------------------------------
  localparam int DW  = HALF_WIDTH * NUM_HALVES;  // data width
  localparam int CW  = RBT_CTL_PER_HALF * NUM_HALVES;
  localparam int SW  = 2 * DW + CW;              // sync width

  // registers are one word each; wider halves cannot fit
  if (DW > 16 || NUM_HALVES > 2 || HALF_WIDTH < 1) begin : g_chk
    $error("rbt_transceiver: unsupported half width or count");
  end

  // ----------------------------------------------------------
  // synchronised pins
  // ----------------------------------------------------------
  logic [SW-1:0]         pins_raw;  // all pins as a bundle
  logic [SW-1:0]         pins_sync; // after two flip-flops
  logic [DW-1:0]         a_sync;    // port a level
  logic [DW-1:0]         b_sync;    // port b level
  logic [NUM_HALVES-1:0] oe_s;      // output enable, active high
  logic [NUM_HALVES-1:0] oe_n_s;    // output enable, active low
  logic [NUM_HALVES-1:0] dir_s;     // direction
  logic [NUM_HALVES-1:0] sab_s;     // a-to-b source select
  logic [NUM_HALVES-1:0] sba_s;     // b-to-a source select
  logic [NUM_HALVES-1:0] cpa_s;     // a capture clock level
  logic [NUM_HALVES-1:0] cpb_s;     // b capture clock level

  // fixed packing, unpacked again below
  // enable goes through inverted so a cleared synchroniser
  // reads as disabled and no port drives right after reset
  assign pins_raw = {port_a_data_in, port_b_data_in,
                     ~output_enable_n, transfer_direction,
                     source_select_a_to_b, source_select_b_to_a,
                     capture_clock_a_side, capture_clock_b_side};

  // one synchroniser covers every pin of both halves
  rbt_sync #(
    .WIDTH(SW)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  assign {a_sync, b_sync, oe_s, dir_s, sab_s, sba_s,
          cpa_s, cpb_s} = pins_sync;
  assign oe_n_s = ~oe_s;

  // ----------------------------------------------------------
  // capture clock edge detection
  // ----------------------------------------------------------
  logic [NUM_HALVES-1:0] cpa_prev;      // last a clock level
  logic [NUM_HALVES-1:0] cpb_prev;      // last b clock level
  logic [NUM_HALVES-1:0] next_cpa_prev; // next a clock level
  logic [NUM_HALVES-1:0] next_cpb_prev; // next b clock level
  logic [NUM_HALVES-1:0] cpa_rise;      // a rising, one cycle
  logic [NUM_HALVES-1:0] cpb_rise;      // b rising, one cycle

  // edges come from the second stage only, so the
  // metastable first stage never reaches this logic
  always_comb begin
    next_cpa_prev = clk_en ? cpa_s : cpa_prev;
    next_cpb_prev = clk_en ? cpb_s : cpb_prev;
    cpa_rise      = clk_en ? (cpa_s & ~cpa_prev) : '0;
    cpb_rise      = clk_en ? (cpb_s & ~cpb_prev) : '0;
  end

  // previous levels; zero so a high clock at release
  // counts as one rising edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpa_prev <= '0;
      cpb_prev <= '0;
    end else begin
      cpa_prev <= next_cpa_prev;
      cpb_prev <= next_cpb_prev;
    end
  end

  // ----------------------------------------------------------
  // software registers
  // ----------------------------------------------------------
  logic [1:0]  iso;          // force isolation per half
  logic [1:0]  next_iso;     // next isolation bits
  logic [15:0] cnt_a;        // a-side capture events
  logic [15:0] cnt_b;        // b-side capture events
  logic [15:0] next_cnt_a;   // next a count
  logic [15:0] next_cnt_b;   // next b count
  logic        wr_ctrl;      // write strobe to control
  logic        cnt_clr;      // counter clear request

  // ----------------------------------------------------------
  // halves
  // ----------------------------------------------------------
  logic [DW-1:0] st_a;  // stored a words, all halves
  logic [DW-1:0] st_b;  // stored b words, all halves

  // one instance per half, nothing shared between them
  for (genvar h = 0; h < NUM_HALVES; h++) begin : g_half
    localparam int LO = h * HALF_WIDTH;
    rbt_half #(
      .WIDTH(HALF_WIDTH)
    ) u_half (
      .core_clk            (core_clk),
      .rst_n               (rst_n),
      .clk_en              (clk_en),
      .output_enable_n     (oe_n_s[h]),
      .transfer_direction  (dir_s[h]),
      .source_select_a_to_b(sab_s[h]),
      .source_select_b_to_a(sba_s[h]),
      .capture_a_rise      (cpa_rise[h]),
      .capture_b_rise      (cpb_rise[h]),
      .force_isolate       (iso[h]),
      .a_in                (a_sync[LO +: HALF_WIDTH]),
      .b_in                (b_sync[LO +: HALF_WIDTH]),
      .a_out               (port_a_data_out[LO +: HALF_WIDTH]),
      .a_oe                (port_a_data_oe[LO +: HALF_WIDTH]),
      .b_out               (port_b_data_out[LO +: HALF_WIDTH]),
      .b_oe                (port_b_data_oe[LO +: HALF_WIDTH]),
      .stored_a            (st_a[LO +: HALF_WIDTH]),
      .stored_b            (st_b[LO +: HALF_WIDTH])
    );
  end

  // ----------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------
  rbt_wb_state_e state;      // slave state
  rbt_wb_state_e next_state; // next slave state
  logic          next_ack;   // next acknowledge
  logic [31:0]   next_dat;   // next read data
  logic [31:0]   rd_word;    // decoded read word
  logic          req;        // new request this cycle
  logic [5:0]    word_adr;   // word index of the access

  // decode and read multiplexer
  always_comb begin
    word_adr = wb_adr_i[7:2];
    rd_word  = RBT_DAT_RST;  // unmapped reads give zero
    unique case (word_adr)
      RBT_OFS_ID[7:2]: begin
        rd_word = RBT_BLOCK_TAG;
      end
      RBT_OFS_CTRL[7:2]: begin
        rd_word[RBT_CTRL_ISO_POS +: 2] = iso;
      end
      RBT_OFS_STORE_A[7:2]: begin
        rd_word[DW-1:0] = st_a;
      end
      RBT_OFS_STORE_B[7:2]: begin
        rd_word[DW-1:0] = st_b;
      end
      RBT_OFS_PINS[7:2]: begin
        rd_word[RBT_PIN_OE_POS  +: NUM_HALVES] = oe_n_s;
        rd_word[RBT_PIN_DIR_POS +: NUM_HALVES] = dir_s;
        rd_word[RBT_PIN_SAB_POS +: NUM_HALVES] = sab_s;
        rd_word[RBT_PIN_SBA_POS +: NUM_HALVES] = sba_s;
        rd_word[RBT_PIN_CPA_POS +: NUM_HALVES] = cpa_s;
        rd_word[RBT_PIN_CPB_POS +: NUM_HALVES] = cpb_s;
      end
      RBT_OFS_COUNT[7:2]: begin
        rd_word = {cnt_b, cnt_a};
      end
      default: begin
        rd_word = RBT_DAT_RST;
      end
    endcase
  end

  // one request, one ack the cycle after; the ack state
  // ignores the held request so it is never answered twice
  always_comb begin
    req        = wb_cyc_i && wb_stb_i;
    next_state = state;
    next_ack   = 1'b0;
    next_dat   = wb_dat_o;
    wr_ctrl    = 1'b0;
    unique case (state)
      RBT_WB_IDLE: begin
        if (req) begin
          next_state = RBT_WB_ACK;
          next_ack   = 1'b1;
          next_dat   = wb_we_i ? RBT_DAT_RST : rd_word;
          wr_ctrl    = wb_we_i && (word_adr == RBT_OFS_CTRL[7:2]);
        end
      end
      RBT_WB_ACK: begin
        next_state = RBT_WB_IDLE;
      end
    endcase
    if (!clk_en) begin
      next_state = state;
      next_ack   = wb_ack_o;
      next_dat   = wb_dat_o;
      wr_ctrl    = 1'b0;
    end
  end

  // slave state and answer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= RBT_WB_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= RBT_DAT_RST;
    end else begin
      state    <= next_state;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // ----------------------------------------------------------
  // control register and event counters
  // ----------------------------------------------------------
  // a clear and an event in one cycle leave the count at one,
  // so no capture is ever lost to a clear
  always_comb begin
    next_iso = iso;
    cnt_clr  = 1'b0;
    if (wr_ctrl && wb_sel_i[0]) begin
      next_iso = wb_dat_i[RBT_CTRL_ISO_POS +: 2];
    end
    if (wr_ctrl && wb_sel_i[1]) begin
      cnt_clr = wb_dat_i[RBT_CTRL_CLR_POS];
    end
    next_cnt_a = (cnt_clr ? RBT_CNT_RST : cnt_a)
               + {15'h0000, |cpa_rise};
    next_cnt_b = (cnt_clr ? RBT_CNT_RST : cnt_b)
               + {15'h0000, |cpb_rise};
    if (!clk_en) begin
      next_cnt_a = cnt_a;
      next_cnt_b = cnt_b;
    end
  end

  // control and counter registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      iso   <= RBT_CTRL_ISO_RST;
      cnt_a <= RBT_CNT_RST;
      cnt_b <= RBT_CNT_RST;
    end else begin
      iso   <= next_iso;
      cnt_a <= next_cnt_a;
      cnt_b <= next_cnt_b;
    end
  end
endmodule : rbt_transceiver
`default_nettype wire

// File: verification/rbt_far_bus.sv
// rbt_far_bus: far-side parallel bus, resolves one 16-bit wire
// assumes device drive and enable arrive per bit
`timescale 1ns/1ps
`default_nettype none
module rbt_far_bus (
  input  wire logic        core_clk,
  input  wire logic [15:0] dev_out,
  input  wire logic [15:0] dev_oe,
  input  wire logic [15:0] drv_val,
  input  wire logic [15:0] drv_en,
  output var  logic [15:0] wire_lvl
);
  logic [15:0] last = 16'h0000; // previous wire level
  // released bits flip each cycle so a float never looks stable
  always_ff @(posedge core_clk) begin
    last <= wire_lvl;
  end
  // far side yields every bit the device drives
  always_comb begin
    wire_lvl = (dev_oe & dev_out)
             | (~dev_oe & drv_en & drv_val)
             | (~dev_oe & ~drv_en & ~last);
  end
endmodule : rbt_far_bus
`default_nettype wire

// File: verification/rbt_transceiver_asserts.sv
// rbt_transceiver_asserts: port-level checks on the transceiver
// assumes force-isolate stays clear and clk_en is held high
`timescale 1ns/1ps
`default_nettype none
module rbt_transceiver_asserts #(
  parameter int HALF_WIDTH = rbt_pkg::RBT_HALF_WIDTH,
  parameter int NUM_HALVES = rbt_pkg::RBT_NUM_HALVES
) (
  input wire logic                             core_clk,
  input wire logic                             rst_n,
  input wire logic                             clk_en,
  input wire logic [NUM_HALVES-1:0]            output_enable_n,
  input wire logic [NUM_HALVES-1:0]            transfer_direction,
  input wire logic [NUM_HALVES-1:0]            source_select_a_to_b,
  input wire logic [NUM_HALVES-1:0]            source_select_b_to_a,
  input wire logic [HALF_WIDTH*NUM_HALVES-1:0] port_a_data_in,
  input wire logic [HALF_WIDTH*NUM_HALVES-1:0] port_a_data_out,
  input wire logic [HALF_WIDTH*NUM_HALVES-1:0] port_a_data_oe,
  input wire logic [HALF_WIDTH*NUM_HALVES-1:0] port_b_data_in,
  input wire logic [HALF_WIDTH*NUM_HALVES-1:0] port_b_data_out,
  input wire logic [HALF_WIDTH*NUM_HALVES-1:0] port_b_data_oe,
  input wire logic                             wb_cyc_i,
  input wire logic                             wb_stb_i,
  input wire logic                             wb_ack_o
);
  import rbt_pkg::*;
  // ------------------------------------------------------------
  // timing frame: pins reach the outputs after three edges
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // half 0 passes live b onto a with b held still
  sequence s_a_live;
    (!output_enable_n[0] && !transfer_direction[0] &&
     !source_select_b_to_a[0] && $stable(port_b_data_in[7:0]))[*4];
  endsequence
  // half 1 passes live a onto b with a held still
  sequence s_b_live;
    (!output_enable_n[1] && transfer_direction[1] &&
     !source_select_a_to_b[1] && $stable(port_a_data_in[15:8]))[*4];
  endsequence
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_one_driver: assert property (
    (port_a_data_oe & port_b_data_oe) == '0)
    else $error("a and b driven on the same bit");
  a_off_half0: assert property (
    output_enable_n[0] [*4] |=>
      port_a_data_oe[7:0] == 8'h00 && port_b_data_oe[7:0] == 8'h00)
    else $error("half 0 drives while disabled");
  a_off_half1: assert property (
    output_enable_n[1] [*4] |=>
      port_a_data_oe[15:8] == 8'h00 && port_b_data_oe[15:8] == 8'h00)
    else $error("half 1 drives while disabled");
  a_a_drive: assert property (
    (!output_enable_n[0] && !transfer_direction[0]) [*4] |=>
      port_a_data_oe[7:0] == 8'hff && port_b_data_oe[7:0] == 8'h00)
    else $error("half 0 not driving a only");
  a_a_live: assert property (
    s_a_live |=> port_a_data_out[7:0] == $past(port_b_data_in[7:0]))
    else $error("live b not seen on a");
  a_b_live: assert property (
    s_b_live |=> port_b_data_oe[15:8] == 8'hff &&
      port_b_data_out[15:8] == $past(port_a_data_in[15:8]))
    else $error("live a not seen on b");
  a_reset_float: assert property (
    $rose(rst_n) |-> port_a_data_oe == '0 && port_b_data_oe == '0 &&
      !wb_ack_o)
    else $error("outputs active after reset");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (
    (wb_cyc_i && wb_stb_i && clk_en && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
endmodule : rbt_transceiver_asserts
bind rbt_transceiver rbt_transceiver_asserts #(
  .HALF_WIDTH(HALF_WIDTH), .NUM_HALVES(NUM_HALVES)
) i_rbt_transceiver_asserts (
  .core_clk, .rst_n, .clk_en, .output_enable_n, .transfer_direction,
  .source_select_a_to_b, .source_select_b_to_a, .port_a_data_in,
  .port_a_data_out, .port_a_data_oe, .port_b_data_in, .port_b_data_out,
  .port_b_data_oe, .wb_cyc_i, .wb_stb_i, .wb_ack_o
);
`default_nettype wire

// File: verification/testbench.sv
// testbench: drives pins and bus of the transceiver
// assumes two far-bus models resolve the a and b wires
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rbt_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        core_clk, rst_n, clk_en;       // clock, reset, run
  logic [1:0]  oe_n, dir, sab, sba, cpa, cpb; // per-half pins
  logic [15:0] a_drv, a_en, b_drv, b_en;      // far-side drive
  logic [15:0] a_wire, b_wire, a_out, a_oe, b_out, b_oe;
  logic        cyc, stb, we, ack;             // bus handshake
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, rd;
  int          fail_count, tests_run;
  // 40 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  rbt_transceiver i_rbt_transceiver (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .output_enable_n(oe_n), .transfer_direction(dir),
    .capture_clock_a_side(cpa), .capture_clock_b_side(cpb),
    .source_select_a_to_b(sab), .source_select_b_to_a(sba),
    .port_a_data_in(a_wire), .port_a_data_out(a_out),
    .port_a_data_oe(a_oe), .port_b_data_in(b_wire),
    .port_b_data_out(b_out), .port_b_data_oe(b_oe),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  rbt_far_bus i_a_bus (.core_clk(core_clk), .dev_out(a_out),
    .dev_oe(a_oe), .drv_val(a_drv), .drv_en(a_en), .wire_lvl(a_wire));
  rbt_far_bus i_b_bus (.core_clk(core_clk), .dev_out(b_out),
    .dev_oe(b_oe), .drv_val(b_drv), .drv_en(b_en), .wire_lvl(b_wire));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one classic cycle; waits for ack, no fixed latency assumed
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    check({31'h0, ack}, 32'h1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    check(rd, exp);
  endtask : rchk
  // capture pulse, long enough for the pin synchroniser
  task automatic cap(input logic [1:0] ca, input logic [1:0] cb);
    tick(3);
    cpa <= ca;
    cpb <= cb;
    tick(3);
    cpa <= 2'b00;
    cpb <= 2'b00;
    tick(4);
  endtask : cap
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  // watchdog, far beyond the roughly 140 cycles needed
  initial begin
    tick(5000);
    fail_count++;
    give_verdict();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {rst_n, cyc, stb, we, adr, sel, wdat} = '0;
    {dir, sab, sba, cpa, cpb, fail_count, tests_run} = '0;
    clk_en = 1'b1;
    oe_n = 2'b11;
    {a_drv, a_en, b_drv, b_en} = 64'h5aa5_ffff_3cc3_ffff;
    tick(10);
    rst_n <= 1'b1;
    tick(1);
    check({a_oe, b_oe}, 32'h0);
    rchk(RBT_OFS_ID, RBT_BLOCK_TAG);
    rchk(RBT_OFS_STORE_A, 32'h0);
    rchk(RBT_OFS_STORE_B, 32'h0);
    rchk(8'h1c, 32'h0);
    bus(1'b1, RBT_OFS_ID, 32'hffff_ffff, 4'hf);
    rchk(RBT_OFS_ID, RBT_BLOCK_TAG);
    // isolation: both registers loaded together, then held
    cap(2'b11, 2'b11);
    check({a_oe, b_oe}, 32'h0);
    a_drv <= 16'h1234;
    tick(5);
    rchk(RBT_OFS_STORE_A, 32'h0000_5aa5);
    rchk(RBT_OFS_STORE_B, 32'h0000_3cc3);
    // half 0 drives a from stored b, half 1 stays off
    oe_n <= 2'b10;
    sba <= 2'b01;
    a_en <= 16'hff00;
    tick(5);
    check({a_oe, b_oe}, 32'h00ff_0000);
    check(a_out[7:0], 8'hc3);
    sba <= 2'b00;
    b_drv <= 16'h3c81;
    tick(5);
    check(a_out[7:0], 8'h81);
    // capture both registers while a is being driven
    b_drv <= 16'h3c42;
    tick(4);
    cap(2'b01, 2'b01);
    rchk(RBT_OFS_STORE_B, 32'h0000_3c42);
    rchk(RBT_OFS_STORE_A, 32'h0000_5a42);
    // half 1 drives b, first stored a, then live a
    oe_n <= 2'b00;
    dir <= 2'b10;
    sab <= 2'b10;
    b_en <= 16'h00ff;
    tick(5);
    check({a_oe, b_oe}, 32'h00ff_ff00);
    check(b_out[15:8], 8'h5a);
    sab <= 2'b00;
    a_drv <= 16'h9934;
    tick(5);
    check(b_out[15:8], 8'h99);
    rchk(RBT_OFS_PINS, 32'h0000_0008);
    rchk(RBT_OFS_COUNT, 32'h0002_0002);
    bus(1'b1, RBT_OFS_CTRL, 32'h0000_0100, 4'h2);
    rchk(RBT_OFS_COUNT, 32'h0);
    rchk(RBT_OFS_CTRL, 32'h0);
    // isolate half 1 while it drives stored a onto b
    sab <= 2'b10;
    bus(1'b1, RBT_OFS_CTRL, 32'h0000_0002, 4'h1);
    tick(5);
    check(b_oe[15:8], 8'h00);
    check(a_oe[7:0], 8'hff);
    rchk(RBT_OFS_CTRL, 32'h0000_0002);
    bus(1'b1, RBT_OFS_CTRL, 32'h0, 4'h1);
    tick(5);
    check(b_oe[15:8], 8'hff);
    sab <= 2'b00;
    tick(5);
    // reset in mid-run floats the ports and clears storage
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    tick(1);
    check({a_oe, b_oe}, 32'h0);
    rchk(RBT_OFS_STORE_A, 32'h0);
    rchk(RBT_OFS_STORE_B, 32'h0);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
